// ### verilog/load_memory_pkg.sv
// Package: opcodes, field positions and timing of the load memory instruction unit
package load_memory_pkg;
  // ------------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_INDEX_LOAD   = 8'h87;
  localparam logic [7:0] OP_INDEX_STORE  = 8'h97;
  localparam logic [7:0] OP_IND_IMM      = 8'hD6;
  localparam logic [7:0] OP_BIT_LOAD     = 8'h47;
  localparam logic [7:0] OP_MEM_LOAD     = 8'hC3;
  localparam logic [7:0] OP_MEM_STORE    = 8'hD3;
  localparam logic [7:0] OP_SHORT_LOAD   = 8'hE7;
  localparam logic [7:0] OP_SHORT_STORE  = 8'hF7;
  localparam logic [7:0] OP_LONG_LOAD    = 8'hA7;
  localparam logic [7:0] OP_LONG_STORE   = 8'hB7;
  localparam logic [7:0] OP_LOAD_POSTDEC = 8'hE2;
  localparam logic [7:0] OP_LOAD_POSTINC = 8'hE3;
  localparam logic [7:0] OP_STORE_PREDEC = 8'hF2;
  // ------------------------------------------------------------------
  // Field layout and special values
  // ------------------------------------------------------------------
  localparam logic [3:0] DIRECT_PROGRAM  = 4'h0;
  localparam logic [3:0] DIRECT_DATA     = 4'h1;
  localparam logic [3:0] WORK_BANK       = 4'hC;  // Working registers sit at 0xC0..0xCF
  localparam int         BIT_DIR_POS     = 0;
  localparam int         BIT_NUM_LSB     = 1;
  localparam int         BIT_REG_LSB     = 4;
  // ------------------------------------------------------------------
  // Instruction cycle counts
  // ------------------------------------------------------------------
  localparam logic [4:0] CYC_SHORT       = 5'h06;
  localparam logic [4:0] CYC_INDIRECT    = 5'h0A;
  localparam logic [4:0] CYC_DISP_SHORT  = 5'h0C;
  localparam logic [4:0] CYC_DISP_LONG   = 5'h0E;
  localparam logic [4:0] CYC_PREDEC      = 5'h0E;

  // Instruction bytes as handed over by the fetch stage
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } instr_s;

  // One access to the register file
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_s;

  // One access to program or data memory
  typedef struct packed {
    logic        req;
    logic        we;
    logic        data_space;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;
endpackage : load_memory_pkg

// ### verilog/load_memory_instruction_unit.sv
// Execution of byte, bit and memory load instructions of an 8-bit core
`timescale 1ns/1ps
`default_nettype none

// Function
// - Indexed load/store adds index to offset
// - D6 writes immediate through register pointer
// - Bit load copies one bit, 6 cycles
// - Byte two: register, bit number, direction
// - Bit load changes only target bit
// - Even pair program memory, odd data memory
// - C3 load, D3 store, 10 cycles
// - E7/F7 add one-byte displacement, 12 cycles
// - A7/B7 add two-byte displacement, 14 cycles
// - Nibble 0000/0001 selects direct absolute address
// - Data memory spans full 16-bit space
// - Masked ROM parts refuse memory transfers
// - E2 loads then decrements pointer pair
// - E3 loads then increments pointer pair
// - Pre-decrement updates pointer before the access
module load_memory_instruction_unit #(
  parameter bit MASKED_ROM = 1'b0
) (
  input  wire logic                         sys_clk,
  input  wire logic                         srst,
  input  wire logic                         start,
  input  wire load_memory_pkg::instr_s      instr,
  input  wire logic [7:0]                   reg_rdata_a,
  input  wire logic [7:0]                   reg_rdata_b,
  input  wire logic [7:0]                   reg_rdata_c,
  input  wire logic [7:0]                   mem_rdata,
  output logic [7:0]                        reg_raddr_a,
  output logic [7:0]                        reg_raddr_b,
  output logic [7:0]                        reg_raddr_c,
  output load_memory_pkg::reg_write_s       reg_wr,
  output load_memory_pkg::reg_write_s       ptr_wr,
  output load_memory_pkg::mem_req_s         mem,
  output logic                              busy,
  output logic                              done,
  output logic                              illegal
);
  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, FETCH, EXEC, WAIT} state_e;

  state_e                    state;
  state_e                    next_state;
  load_memory_pkg::instr_s   ir;
  logic [4:0]                cycles;
  logic [4:0]                next_cycles;

  // Decode of the latched instruction
  wire logic [3:0] op_hi     = ir.byte1[7:4];
  wire logic [3:0] op_lo     = ir.byte1[3:0];
  wire logic is_idx_ld  = ir.opcode == load_memory_pkg::OP_INDEX_LOAD;
  wire logic is_idx_st  = ir.opcode == load_memory_pkg::OP_INDEX_STORE;
  wire logic is_ind_imm = ir.opcode == load_memory_pkg::OP_IND_IMM;
  wire logic is_bit     = ir.opcode == load_memory_pkg::OP_BIT_LOAD;
  wire logic is_ind_ld  = ir.opcode == load_memory_pkg::OP_MEM_LOAD;
  wire logic is_ind_st  = ir.opcode == load_memory_pkg::OP_MEM_STORE;
  wire logic is_xs_ld   = ir.opcode == load_memory_pkg::OP_SHORT_LOAD;
  wire logic is_xs_st   = ir.opcode == load_memory_pkg::OP_SHORT_STORE;
  wire logic is_xl_ld   = ir.opcode == load_memory_pkg::OP_LONG_LOAD;
  wire logic is_xl_st   = ir.opcode == load_memory_pkg::OP_LONG_STORE;
  wire logic is_pdec    = ir.opcode == load_memory_pkg::OP_LOAD_POSTDEC;
  wire logic is_pinc    = ir.opcode == load_memory_pkg::OP_LOAD_POSTINC;
  wire logic is_prdec   = ir.opcode == load_memory_pkg::OP_STORE_PREDEC;
  // Direct form shares A7/B7; pair nibbles 0 and 1 never name a long pointer
  wire logic is_long    = is_xl_ld | is_xl_st;
  wire logic is_direct  = is_long & (op_lo == load_memory_pkg::DIRECT_PROGRAM
                                   | op_lo == load_memory_pkg::DIRECT_DATA);
  wire logic is_memop   = is_ind_ld | is_ind_st | is_xs_ld | is_xs_st | is_long
                        | is_pdec | is_pinc | is_prdec;
  wire logic is_regop   = is_idx_ld | is_idx_st | is_ind_imm | is_bit;
  wire logic refused    = is_memop & MASKED_ROM;
  wire logic mem_store  = is_ind_st | is_xs_st | is_xl_st | is_prdec;

  // Register read addresses: a = working register (register named by byte two for D6), b/c = pointer pair or operand
  wire logic [7:0] work_reg  = {load_memory_pkg::WORK_BANK, op_hi};
  wire logic [7:0] pair_even = {load_memory_pkg::WORK_BANK, op_lo[3:1], 1'b0};
  wire logic [7:0] pair_odd  = {load_memory_pkg::WORK_BANK, op_lo[3:1], 1'b1};
  wire logic [7:0] idx_reg   = {load_memory_pkg::WORK_BANK, op_lo};
  // Byte two names the working register; byte three is the full register address
  wire logic [7:0] bit_reg   = ir.byte2;
  wire logic [2:0] bit_num   = ir.byte1[load_memory_pkg::BIT_NUM_LSB +: 3];
  wire logic       bit_store = ir.byte1[load_memory_pkg::BIT_DIR_POS];
  wire logic [7:0] bit_work  = {load_memory_pkg::WORK_BANK,
                                ir.byte1[load_memory_pkg::BIT_REG_LSB +: 4]};
  wire logic [7:0] next_raddr_a = is_bit ? bit_work : (is_ind_imm ? ir.byte1 : work_reg);
  wire logic [7:0] next_raddr_b = is_bit ? bit_reg : (is_regop ? idx_reg : pair_even);
  wire logic [7:0] next_raddr_c = pair_odd;

  // Pointer pair and address arithmetic, carry runs across all 16 bits
  wire logic [15:0] ptr      = {reg_rdata_b, reg_rdata_c};
  wire logic [15:0] ptr_inc  = ptr + 16'h0001;
  wire logic [15:0] ptr_dec  = ptr - 16'h0001;
  wire logic [15:0] xs_addr  = ptr + {8'h00, ir.byte2};
  wire logic [15:0] xl_addr  = ptr + {ir.byte3, ir.byte2};
  wire logic [15:0] da_addr  = {ir.byte3, ir.byte2};
  wire logic [15:0] mem_addr = is_direct ? da_addr
                             : is_long ? xl_addr
                             : (is_xs_ld | is_xs_st) ? xs_addr
                             : is_prdec ? ptr_dec
                             : ptr;
  // Even pair selects program memory, odd selects data memory
  wire logic data_space = op_lo[0];

  // Register-side results
  wire logic [7:0] idx_addr  = ir.byte2 + reg_rdata_b;
  wire logic [7:0] bit_ld    = {reg_rdata_a[7:1], reg_rdata_b[bit_num]};
  logic [7:0] bit_st;
  always_comb begin
    bit_st          = reg_rdata_b;
    bit_st[bit_num] = reg_rdata_a[0];
  end

  // Total cycles of each instruction
  wire logic [4:0] instr_cycles =
      (is_ind_ld | is_ind_st | is_pdec | is_pinc) ? load_memory_pkg::CYC_INDIRECT
    : (is_xs_ld | is_xs_st)                      ? load_memory_pkg::CYC_DISP_SHORT
    : is_long                                    ? load_memory_pkg::CYC_DISP_LONG
    : is_prdec                                   ? load_memory_pkg::CYC_PREDEC
    : load_memory_pkg::CYC_SHORT;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    next_state  = state;
    next_cycles = cycles;
    case (state)
      IDLE: begin
        if (start) begin
          next_state = FETCH;
        end
      end
      FETCH: begin
        next_state  = EXEC;
        next_cycles = instr_cycles - 5'h03;  // IDLE->FETCH->EXEC->WAIT spend three edges
      end
      EXEC: begin
        next_state = (is_memop | is_regop) & !refused ? WAIT : IDLE;
      end
      WAIT: begin
        next_cycles = cycles - 5'h01;
        if (cycles == 5'h01) begin
          next_state = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  // Latch the instruction and step the sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state  <= IDLE;
      cycles <= 5'h00;
      ir     <= '0;
    end else begin
      state  <= next_state;
      cycles <= next_cycles;
      if (state == IDLE && start) begin
        ir <= instr;
      end
    end
  end

  // Read addresses are registered so each output comes from a flop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_raddr_a <= 8'h00;
      reg_raddr_b <= 8'h00;
      reg_raddr_c <= 8'h00;
    end else if (state == FETCH) begin
      reg_raddr_a <= next_raddr_a;
      reg_raddr_b <= next_raddr_b;
      reg_raddr_c <= next_raddr_c;
    end else if ((state == EXEC) & is_idx_ld) begin
      // Indexed source is known only once the index register has been read
      reg_raddr_c <= idx_addr;
    end
  end

  // ------------------------------------------------------------------
  // Execute: one register write, two pointer byte writes, one memory access
  // ------------------------------------------------------------------
  wire logic exec_ok = (state == EXEC) & !refused;
  wire logic exec_mem = exec_ok & is_memop;

  // Memory data is taken in the cycle the request stands; load lands in WAIT
  logic load_pending;
  logic idx_pending;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mem          <= '0;
      load_pending <= 1'b0;
      idx_pending  <= 1'b0;
    end else begin
      idx_pending    <= (state == EXEC) & is_idx_ld;
      mem.req        <= exec_mem;
      mem.we         <= exec_mem & mem_store;
      mem.data_space <= data_space;
      mem.addr       <= mem_addr;
      mem.wdata      <= reg_rdata_a;
      load_pending   <= exec_mem & !mem_store;
    end
  end

  // Register writes: register operations in EXEC, indexed load one cycle later, memory loads once data is back
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_wr <= '0;
    end else if (load_pending) begin
      reg_wr <= '{we: 1'b1, addr: work_reg, data: mem_rdata};
    end else if (idx_pending) begin
      reg_wr <= '{we: 1'b1, addr: work_reg, data: reg_rdata_c};
    end else if (exec_ok & is_idx_st) begin
      reg_wr <= '{we: 1'b1, addr: idx_addr, data: reg_rdata_a};
    end else if (exec_ok & is_ind_imm) begin
      reg_wr <= '{we: 1'b1, addr: reg_rdata_a, data: ir.byte2};
    end else if (exec_ok & is_bit) begin
      reg_wr <= bit_store ? '{we: 1'b1, addr: bit_reg, data: bit_st}
                          : '{we: 1'b1, addr: bit_work, data: bit_ld};
    end else begin
      reg_wr.we <= 1'b0;
    end
  end

  // Pointer pair update: high byte first, low byte one cycle later on the same port.
  // A reader of the pair in between would see it half updated.
  wire logic ptr_upd = exec_mem & (is_pdec | is_pinc | is_prdec);
  wire logic [15:0] ptr_new = is_pinc ? ptr_inc : ptr_dec;
  logic [7:0] ptr_low_pending;
  logic       ptr_low_due;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ptr_wr          <= '0;
      ptr_low_pending <= 8'h00;
      ptr_low_due     <= 1'b0;
    end else begin
      ptr_low_pending <= ptr_new[7:0];
      ptr_low_due     <= ptr_upd;
      if (ptr_upd) begin
        ptr_wr <= '{we: 1'b1, addr: pair_even, data: ptr_new[15:8]};
      end else if (ptr_low_due) begin
        ptr_wr <= '{we: 1'b1, addr: pair_odd, data: ptr_low_pending};
      end else begin
        ptr_wr.we <= 1'b0;
      end
    end
  end

  // Status flags
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      illegal <= 1'b0;
    end else begin
      busy    <= next_state != IDLE;
      done    <= (state == WAIT && cycles == 5'h01)
               | (state == EXEC && next_state == IDLE);
      illegal <= (state == EXEC) & (refused | !(is_memop | is_regop));
    end
  end
endmodule : load_memory_instruction_unit

`default_nettype wire

// ### dv/load_memory_monitor.sv
// Checker of the load memory instruction unit ports
`timescale 1ns/1ps
`default_nettype none
module load_memory_monitor #(
  parameter bit MASKED_ROM = 1'b0
) (
  input wire logic                        sys_clk,
  input wire logic                        srst,
  input wire logic                        start,
  input wire load_memory_pkg::instr_s     instr,
  input wire load_memory_pkg::reg_write_s reg_wr,
  input wire load_memory_pkg::reg_write_s ptr_wr,
  input wire load_memory_pkg::mem_req_s   mem,
  input wire logic                        busy,
  input wire logic                        done,
  input wire logic                        illegal
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Accept edge and opcode of the instruction
  wire logic       taken = start && !busy;
  wire logic [7:0] op    = instr.opcode;
  logic            space;
  // Space bit is latched, instr is free to change after the accept edge
  always_ff @(posedge sys_clk) begin
    if (srst) space <= 1'b0;
    else if (taken) space <= instr.byte1[0];
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_space; mem.req |-> mem.data_space == space; endproperty
  property p_rom; !(MASKED_ROM && mem.req); endproperty
  property p_rom_flag; taken && MASKED_ROM && op == 8'hC3 |-> ##3 illegal; endproperty
  property p_bit; taken && op == 8'h47 |-> ##[5:7] done; endproperty
  property p_ind; taken && !MASKED_ROM && op == 8'hC3 |-> ##[9:11] done; endproperty
  property p_short; taken && !MASKED_ROM && op == 8'hE7 |-> ##[11:13] done; endproperty
  property p_long; taken && !MASKED_ROM && op == 8'hA7 |-> ##[13:15] done; endproperty
  property p_load; mem.req && !mem.we |-> ##[1:2] reg_wr.we; endproperty
  property p_ptr; ptr_wr.we |-> ptr_wr.addr[7:4] == 4'hC; endproperty
  property p_ptr_pair; ptr_wr.we && !ptr_wr.addr[0] |=> ptr_wr.we && ptr_wr.addr[0]; endproperty
  property p_reg_only;
    taken && op inside {8'h87, 8'h97, 8'hD6, 8'h47} |=> !mem.req [*6];
  endproperty
  a_space: assert property (p_space) else $error("memory space wrong");
  a_rom: assert property (p_rom) else $error("memory access on masked part");
  a_rom_flag: assert property (p_rom_flag) else $error("no refusal flag");
  a_bit: assert property (p_bit) else $error("bit load length");
  a_ind: assert property (p_ind) else $error("indirect length");
  a_short: assert property (p_short) else $error("short length");
  a_long: assert property (p_long) else $error("long length");
  a_load: assert property (p_load) else $error("load without write");
  a_ptr: assert property (p_ptr) else $error("pointer write address");
  a_ptr_pair: assert property (p_ptr_pair) else $error("pointer low byte missing");
  a_reg_only: assert property (p_reg_only) else $error("memory touched");
  c_store: cover property (mem.req && mem.we);
  c_ptr: cover property (ptr_wr.we);
  c_top: cover property (mem.req && mem.addr == 16'hFFFF);
  c_ill: cover property (illegal);
endmodule : load_memory_monitor
bind load_memory_instruction_unit load_memory_monitor #(.MASKED_ROM(MASKED_ROM)) mon_u (
  .sys_clk(sys_clk), .srst(srst), .start(start), .instr(instr), .reg_wr(reg_wr),
  .ptr_wr(ptr_wr), .mem(mem), .busy(busy), .done(done), .illegal(illegal));
`default_nettype wire

// ### dv/load_memory_mem_model.sv
// Program and data memory model on the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module load_memory_mem_model (
  input  wire logic                      sys_clk,
  input  wire load_memory_pkg::mem_req_s mem,
  output logic [7:0]                     mem_rdata
);
  logic [7:0] prog_mem [65536];
  logic [7:0] data_mem [65536];
  logic [7:0] last;
  // The unit samples read data while its request still stands
  wire logic [7:0] rd_now = mem.data_space ? data_mem[mem.addr] : prog_mem[mem.addr];
  // Address-derived contents: low byte XOR high byte, inverted in data memory
  initial begin
    for (int i = 0; i < 65536; i++) begin
      prog_mem[i] = i[7:0] ^ i[15:8];
      data_mem[i] = ~(i[7:0] ^ i[15:8]);
    end
    last = 8'h00;
  end
  // Two spaces, full 16-bit reach
  always @(posedge sys_clk) begin
    if (mem.req && mem.we && mem.data_space) data_mem[mem.addr] <= mem.wdata;
    if (mem.req && mem.we && !mem.data_space) prog_mem[mem.addr] <= mem.wdata;
    if (mem.req && !mem.we) last <= rd_now;
  end
  // Outside a read request the bus shows the inverse of the last byte
  assign mem_rdata = (mem.req && !mem.we) ? rd_now : ~last;
endmodule : load_memory_mem_model
`default_nettype wire

// ### dv/load_memory_instruction_unit_tb.sv
// Self-checking testbench of the load memory instruction unit
`timescale 1ns/1ps
`default_nettype none
module load_memory_instruction_unit_tb;
  typedef struct packed {
    load_memory_pkg::instr_s ins;
    logic [1:0]  m;   // 0 none, 1 load, 2 store
    logic [15:0] ma;
    logic [7:0]  d;   // Store data or register data
    logic [7:0]  ra;  // Register written, FF for none
    logic [7:0]  pa;  // Pointer high register, 00 for none
    logic [15:0] pd;  // Pointer pair value after the update
  } row_s;
  // Long forms never use pair 0-1 as pointer
  // Loads never touch an address that an earlier row has stored to
  localparam row_s ROWS [20] = '{
    '{32'hC3020000, 2'd1, 16'h0104, 8'h00, 8'hC0, 8'h00, 16'h0000},
    '{32'hC3030000, 2'd1, 16'h0104, 8'h00, 8'hC0, 8'h00, 16'h0000},
    '{32'hD3030000, 2'd2, 16'h0104, 8'h06, 8'hFF, 8'h00, 16'h0000},
    '{32'hE7020100, 2'd1, 16'h0105, 8'h00, 8'hC0, 8'h00, 16'h0000},
    '{32'hF7030100, 2'd2, 16'h0105, 8'h06, 8'hFF, 8'h00, 16'h0000},
    '{32'hA7020010, 2'd1, 16'h1104, 8'h00, 8'hC0, 8'h00, 16'h0000},
    '{32'hB7030010, 2'd2, 16'h1104, 8'h06, 8'hFF, 8'h00, 16'h0000},
    '{32'hA7000411, 2'd1, 16'h1104, 8'h00, 8'hC0, 8'h00, 16'h0000},
    '{32'hA701FFFF, 2'd1, 16'hFFFF, 8'h00, 8'hC0, 8'h00, 16'h0000},
    '{32'hB7010511, 2'd2, 16'h1105, 8'h06, 8'hFF, 8'h00, 16'h0000},
    '{32'hB7000511, 2'd2, 16'h1105, 8'h06, 8'hFF, 8'h00, 16'h0000},
    '{32'hE2060000, 2'd1, 16'h1000, 8'h00, 8'hC0, 8'hC6, 16'h0FFF},
    '{32'hE3070000, 2'd1, 16'h1000, 8'h00, 8'hC0, 8'hC6, 16'h1001},
    '{32'hF2070000, 2'd2, 16'h0FFF, 8'h06, 8'hFF, 8'hC6, 16'h0FFF},
    '{32'h87012000, 2'd0, 16'h0000, 8'h8F, 8'hC0, 8'h00, 16'h0000},
    '{32'h97012000, 2'd0, 16'h0000, 8'h06, 8'h2A, 8'h00, 16'h0000},
    '{32'hD6C13C00, 2'd0, 16'h0000, 8'h3C, 8'h0A, 8'h00, 16'h0000},
    '{32'h47040000, 2'd0, 16'h0000, 8'h07, 8'hC0, 8'h00, 16'h0000},
    '{32'h47010000, 2'd0, 16'h0000, 8'h04, 8'h00, 8'h00, 16'h0000},
    '{32'h4718C600, 2'd0, 16'h0000, 8'h0B, 8'hC1, 8'h00, 16'h0000}};
  logic sys_clk, srst, start, busy, done, illegal, busy2, done2, ill2;
  logic got_done, got_ill, got_ill2, got_req2;
  logic [7:0] reg_rdata_a, reg_rdata_b, reg_rdata_c, mem_rdata, raddr_a, raddr_b, raddr_c;
  logic [7:0] regs [256];
  int mismatches, checked, n_req, n_rw, n_pw;
  load_memory_pkg::instr_s     instr;
  load_memory_pkg::reg_write_s reg_wr, ptr_wr, c_rw, c_pw, c_pw_hi;
  load_memory_pkg::mem_req_s   mem, mem2, c_mem;
  // Register file reads are combinational; writes are not applied, so rows stay independent
  assign reg_rdata_a = regs[raddr_a];
  assign reg_rdata_b = regs[raddr_b];
  assign reg_rdata_c = regs[raddr_c];
  load_memory_instruction_unit dut_u (.sys_clk(sys_clk), .srst(srst), .start(start),
    .instr(instr), .reg_rdata_a(reg_rdata_a), .reg_rdata_b(reg_rdata_b),
    .reg_rdata_c(reg_rdata_c), .mem_rdata(mem_rdata), .reg_raddr_a(raddr_a),
    .reg_raddr_b(raddr_b), .reg_raddr_c(raddr_c), .reg_wr(reg_wr), .ptr_wr(ptr_wr),
    .mem(mem), .busy(busy), .done(done), .illegal(illegal));
  // Masked-ROM part runs the same stream and must refuse memory work
  load_memory_instruction_unit #(.MASKED_ROM(1'b1)) dut_rom_u (.sys_clk(sys_clk), .srst(srst),
    .start(start), .instr(instr), .reg_rdata_a(8'h00), .reg_rdata_b(8'h00),
    .reg_rdata_c(8'h00), .mem_rdata(8'h00), .reg_raddr_a(), .reg_raddr_b(), .reg_raddr_c(),
    .reg_wr(), .ptr_wr(), .mem(mem2), .busy(busy2), .done(done2), .illegal(ill2));
  load_memory_mem_model mem_u (.sys_clk(sys_clk), .mem(mem), .mem_rdata(mem_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Capture of every pulse of the current instruction
  always @(posedge sys_clk) begin
    if (mem.req) begin n_req <= n_req + 1; c_mem <= mem; end
    if (reg_wr.we) begin n_rw <= n_rw + 1; c_rw <= reg_wr; end
    if (ptr_wr.we) begin n_pw <= n_pw + 1; c_pw <= ptr_wr; c_pw_hi <= c_pw; end
    if (done) got_done <= 1'b1;
    if (illegal) got_ill <= 1'b1;
    if (ill2) got_ill2 <= 1'b1;
    if (mem2.req) got_req2 <= 1'b1;
  end
  function automatic logic [7:0] pat(input logic sp, input logic [15:0] a);
    pat = sp ? ~(a[7:0] ^ a[15:8]) : a[7:0] ^ a[15:8];
  endfunction : pat
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic issue(input load_memory_pkg::instr_s ins);
    n_req = 0; n_rw = 0; n_pw = 0;
    got_done = 1'b0; got_ill = 1'b0; got_ill2 = 1'b0; got_req2 = 1'b0;
    instr = ins;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
  endtask : issue
  // Bounded wait for the end of the instruction, then let late writes land
  task automatic finish_wait();
    int k;
    k = 0;
    while (!(got_done || got_ill) && k < 40) begin @(posedge sys_clk); #1 k++; end
    if (!(got_done || got_ill)) begin mismatches++; complete_run(); end
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : finish_wait
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    srst = 1'b1; start = 1'b0; instr = '0; mismatches = 0; checked = 0;
    n_req = 0; n_rw = 0; n_pw = 0;
    got_done = 1'b0; got_ill = 1'b0; got_ill2 = 1'b0; got_req2 = 1'b0;
    for (int i = 0; i < 256; i++) regs[i] = i[7:0] ^ 8'hA5;
    regs[8'h00] = 8'h05; regs[8'hC0] = 8'h06; regs[8'hC1] = 8'h0A;
    regs[8'hC2] = 8'h01; regs[8'hC3] = 8'h04; regs[8'hC6] = 8'h10; regs[8'hC7] = 8'h00;
    repeat (12) @(posedge sys_clk);
    #1 check("reset outputs", 16'h0, 16'({busy, done, illegal, mem.req, reg_wr.we, ptr_wr.we}));
    srst = 1'b0;
    foreach (ROWS[i]) begin
      issue(ROWS[i].ins);
      finish_wait();
      check("mem count", 16'(ROWS[i].m != 2'd0), 16'(n_req));
      check("rom refusal", 16'(ROWS[i].m != 2'd0), 16'(got_ill2));
      check("rom access", 16'h0, 16'(got_req2));
      if (ROWS[i].m != 2'd0) begin
        check("mem addr", ROWS[i].ma, c_mem.addr);
        check("mem space", 16'(ROWS[i].ins.byte1[0]), 16'(c_mem.data_space));
        check("mem we", 16'(ROWS[i].m == 2'd2), 16'(c_mem.we));
      end
      if (ROWS[i].m == 2'd2) check("store data", 16'(ROWS[i].d), 16'(c_mem.wdata));
      check("reg count", 16'(ROWS[i].ra != 8'hFF), 16'(n_rw));
      if (ROWS[i].ra != 8'hFF) begin
        check("reg addr", 16'(ROWS[i].ra), 16'(c_rw.addr));
        check("reg data", 16'(ROWS[i].m == 2'd1 ? pat(ROWS[i].ins.byte1[0], ROWS[i].ma)
          : ROWS[i].d), 16'(c_rw.data));
      end
      check("ptr count", 16'(ROWS[i].pa != 8'h00 ? 2 : 0), 16'(n_pw));
      if (ROWS[i].pa != 8'h00) begin
        check("ptr addr", 16'(ROWS[i].pa), 16'(c_pw_hi.addr));
        check("ptr data", 16'(ROWS[i].pd[15:8]), 16'(c_pw_hi.data));
        check("ptr low addr", 16'(ROWS[i].pa | 8'h01), 16'(c_pw.addr));
        check("ptr low data", 16'(ROWS[i].pd[7:0]), 16'(c_pw.data));
      end
    end
    // Unknown opcode is flagged and leaves memory alone
    issue(32'hFF000000);
    finish_wait();
    check("unknown flag", 16'h1, 16'(got_ill));
    check("unknown mem", 16'h0, 16'(n_req));
    // A start while busy is ignored
    issue(32'hC3020000);
    repeat (3) @(posedge sys_clk);
    #1 instr = 32'hD3030000;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    finish_wait();
    check("busy refuse count", 16'h1, 16'(n_req));
    check("busy refuse we", 16'h0, 16'(c_mem.we));
    // Reset in mid-instruction, then a clean instruction
    issue(32'hA7020010);
    @(posedge sys_clk);
    #1 srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 check("mid reset", 16'h0, 16'({busy, done, mem.req, reg_wr.we}));
    srst = 1'b0;
    issue(ROWS[12].ins);
    finish_wait();
    check("after reset ptr", 16'h2, 16'(n_pw));
    complete_run();
  end
endmodule : load_memory_instruction_unit_tb
`default_nettype wire
